// [verilog/core_subset_pkg.sv]
/*
  Shared constants and carrier types for the instruction subset execution
  unit: opcode patterns, field positions, special file addresses and the
  last quarter-cycle phase. Assumes a 14-bit instruction word and a 7-bit
  file address space with an external data memory.
*/
package core_subset_pkg;

  localparam int INSN_W = 14;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;

  // Last of the four quarter phases in one instruction cycle.
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Opcode top bits [13:8] for byte-oriented forms.
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam logic [5:0] OP_OR_LIT = 6'h38;
  // Branch is identified by bits [13:11].
  localparam logic [2:0] OP_BRANCH = 3'h5;

  // Field positions.
  localparam int DEST_BIT = 7;
  localparam int BRANCH_K_W = 11;
  localparam int LATCH_PAGE_LO = 3;
  localparam int LATCH_PAGE_HI = 4;
  // Prescaler assignment bit in the option register: 1 = watchdog.
  localparam int PRESCALER_TO_WDT_BIT = 3;

  // Special file addresses.
  localparam logic [6:0] ADDR_TIMER_ZERO = 7'h01;
  localparam logic [6:0] ADDR_PORT = 7'h05;

  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;

  // Result of one executed instruction, for write-back to file memory.
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_t;

endpackage : core_subset_pkg

// [verilog/cpu_instruction_subset_exec.sv]
/*
  Execution unit for a subset of a 14-bit instruction set: decrement or
  increment with skip, unconditional branch, OR with literal and with file.
  Assumes an external file memory with combinational read data for the
  address presented, an external program memory supplying insn_in for the
  current program counter, and the port pin levels synchronised here.
*/
// Notes on behaviour
// - A port register used as its own source reads the pin levels.
// - Writing the timer count clears the prescaler when assigned to it.
// - PC changes and true skips take two cycles, the second a no-op.
// - Decrement-skip subtracts one from file 0..127, flags untouched.
// - A zero decrement result squashes the next instruction.
// - Increment-skip adds one, flags untouched, zero squashes the next.
// - Branch loads PC[10:0] from the immediate, PC[12:11] from latch[4:3].
// - Branch always takes two cycles and alters no flag.
// - OR-literal ORs W with the 8-bit literal into W and updates zero.
// - OR-file ORs W with the file register and updates zero.
// - Destination bit clear sends the result to W, set to the file.
// - An instruction cycle spans four clock periods.
`timescale 1ns/1ps
module cpu_instruction_subset_exec (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [13:0] insn_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic [7:0] port_pins_in,
  input wire logic [7:0] program_counter_high_latch_in,
  input wire logic [7:0] option_in,
  output logic [6:0] file_addr_out,
  output core_subset_pkg::file_write_t file_write_out,
  output logic [12:0] pc_out,
  output logic [7:0] w_out,
  output logic zero_flag_out,
  output logic prescaler_clear_out,
  output logic cycle_end_out,
  output logic squash_out
);

  typedef enum logic [1:0] {
    PHASE_Q1 = 2'b00,
    PHASE_Q2 = 2'b01,
    PHASE_Q3 = 2'b10,
    PHASE_Q4 = 2'b11
  } phase_t;

  phase_t phase;
  phase_t next_phase;
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;
  logic squash;
  logic [7:0] src;
  logic [7:0] result;
  logic write_file;
  logic write_w;
  logic sets_zero;
  logic take_two;
  logic is_branch;
  logic [12:0] next_pc;
  logic cycle_end;

  function automatic logic is_byte_op(input logic [13:0] insn,
                                      input logic [5:0] op);
    is_byte_op = (insn[13:8] == op);
  endfunction : is_byte_op

  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction : is_zero

  function automatic logic addr_is(input logic [13:0] insn,
                                   input logic [6:0] addr);
    addr_is = (insn[6:0] == addr);
  endfunction : addr_is

  always_comb begin
    unique case (phase)
      PHASE_Q1: next_phase = PHASE_Q2;
      PHASE_Q2: next_phase = PHASE_Q3;
      PHASE_Q3: next_phase = PHASE_Q4;
      PHASE_Q4: next_phase = PHASE_Q1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase <= PHASE_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  assign cycle_end = (phase == core_subset_pkg::PHASE_LAST);
  assign cycle_end_out = cycle_end;

  // Pin levels pass two flops before the port read may use them.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
    end else begin
      pins_meta <= port_pins_in;
      pins_sync <= pins_meta;
    end
  end

  // File memory answers combinationally for the operand address.
  assign file_addr_out = insn_in[6:0];

  always_comb begin
    if (addr_is(insn_in, core_subset_pkg::ADDR_PORT)) begin
      src = pins_sync;
    end else begin
      src = file_rdata_in;
    end
  end

  always_comb begin
    result = w_out;
    write_file = 1'b0;
    write_w = 1'b0;
    sets_zero = 1'b0;
    take_two = 1'b0;
    is_branch = 1'b0;
    next_pc = pc_out + 13'h0001;
    if (is_byte_op(insn_in, core_subset_pkg::OP_DEC_SKIP)) begin
      result = src - 8'h01;
      write_file = insn_in[core_subset_pkg::DEST_BIT];
      write_w = !insn_in[core_subset_pkg::DEST_BIT];
      take_two = is_zero(result);
    end else if (is_byte_op(insn_in, core_subset_pkg::OP_INC_SKIP)) begin
      result = src + 8'h01;
      write_file = insn_in[core_subset_pkg::DEST_BIT];
      write_w = !insn_in[core_subset_pkg::DEST_BIT];
      take_two = is_zero(result);
    end else if (is_byte_op(insn_in, core_subset_pkg::OP_OR_FILE)) begin
      result = w_out | src;
      write_file = insn_in[core_subset_pkg::DEST_BIT];
      write_w = !insn_in[core_subset_pkg::DEST_BIT];
      sets_zero = 1'b1;
    end else if (is_byte_op(insn_in, core_subset_pkg::OP_OR_LIT)) begin
      result = w_out | insn_in[7:0];
      write_w = 1'b1;
      sets_zero = 1'b1;
    end else if (insn_in[13:11] == core_subset_pkg::OP_BRANCH) begin
      is_branch = 1'b1;
      next_pc = {program_counter_high_latch_in[
                   core_subset_pkg::LATCH_PAGE_HI:
                   core_subset_pkg::LATCH_PAGE_LO],
                 insn_in[10:0]};
      take_two = 1'b1;
    end
  end

  // A squashed cycle never arms another squash, so skips cannot chain.
  // second cycle executes as a no-op.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      squash <= 1'b0;
    end else if (cycle_end) begin
      squash <= !squash && take_two;
    end
  end

  assign squash_out = squash;

  // The counter also steps in a squashed cycle, which is the fetch stall.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pc_out <= core_subset_pkg::PC_RESET;
    end else if (cycle_end) begin
      if (squash || !is_branch) begin
        pc_out <= pc_out + 13'h0001;
      end else begin
        pc_out <= next_pc;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      w_out <= core_subset_pkg::W_RESET;
    end else if (cycle_end && !squash && write_w) begin
      w_out <= result;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      zero_flag_out <= 1'b0;
    end else if (cycle_end && !squash && sets_zero) begin
      zero_flag_out <= is_zero(result);
    end
  end

  // Write-back and the clear pulse both follow the commit edge.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      file_write_out <= '0;
      prescaler_clear_out <= 1'b0;
    end else begin
      file_write_out.valid <= cycle_end && !squash && write_file;
      file_write_out.addr <= insn_in[6:0];
      file_write_out.data <= result;
      prescaler_clear_out <= cycle_end && !squash && write_file &&
        addr_is(insn_in, core_subset_pkg::ADDR_TIMER_ZERO) &&
        !option_in[core_subset_pkg::PRESCALER_TO_WDT_BIT];
    end
  end

endmodule : cpu_instruction_subset_exec

// [testbench/exec_monitor.sv]
/* Port assertions for the execution unit.
   Bound into every instance of it; sees its ports only. */
`timescale 1ns/1ps
module exec_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [13:0] insn_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic [7:0] program_counter_high_latch_in,
  input wire logic [7:0] option_in,
  input wire logic [12:0] pc_out,
  input wire logic [7:0] w_out,
  input wire logic zero_flag_out,
  input wire logic prescaler_clear_out,
  input wire logic cycle_end_out,
  input wire logic squash_out
);
  wire go = cycle_end_out & ~squash_out;
  wire dz = go & insn_in[13:8] == core_subset_pkg::OP_DEC_SKIP;
  wire br = go & insn_in[13:11] == core_subset_pkg::OP_BRANCH;
  wire ol = go & insn_in[13:8] == core_subset_pkg::OP_OR_LIT;
  wire pt = insn_in[6:0] == core_subset_pkg::ADDR_PORT;
  wire tz = insn_in[6:0] == core_subset_pkg::ADDR_TIMER_ZERO;
  wire wd = option_in[3];
  wire [12:0] tgt = {program_counter_high_latch_in[4:3], insn_in[10:0]};
  wire [7:0] orv = w_out | insn_in[7:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence idle3; !cycle_end_out [*3]; endsequence
  sequence noop4; squash_out [*4]; endsequence
  cycle_four_a: assert property (cycle_end_out |=> idle3 ##1 cycle_end_out)
    else $error("bad cycle length");
  branch_pc_a: assert property (br |=> pc_out == $past(tgt))
    else $error("bad branch target");
  branch_noop_a: assert property (br |=> noop4)
    else $error("no idle cycle");
  flags_kept_a: assert property (dz | br |=> $stable(zero_flag_out))
    else $error("flag changed");
  dec_to_w_a: assert property (dz & ~insn_in[7] & ~pt |=>
    w_out == $past(file_rdata_in) - 8'h01) else $error("bad decrement");
  dec_skip_a: assert property (dz & ~pt |=>
    squash_out == ($past(file_rdata_in) == 8'h01)) else $error("bad skip");
  or_lit_a: assert property (ol |=> w_out == $past(orv))
    else $error("bad or result");
  zero_flag_a: assert property (ol |=> zero_flag_out == (w_out == 8'h00))
    else $error("bad zero flag");
  timer_clr_a: assert property (dz & insn_in[7] & tz |=>
    prescaler_clear_out == !$past(wd)) else $error("bad clear");
endmodule : exec_monitor
bind cpu_instruction_subset_exec exec_monitor exec_monitor_inst (
  .clk_in, .rst_b_in, .insn_in, .file_rdata_in, .option_in,
  .program_counter_high_latch_in, .pc_out, .w_out, .zero_flag_out,
  .prescaler_clear_out, .cycle_end_out, .squash_out);

// [testbench/tb_cpu_instruction_subset_exec.sv]
/* Self-checking bench for the execution unit.
   Drives all inputs itself at the falling clock edge. */
`timescale 1ns/1ps
module tb_cpu_instruction_subset_exec;
  localparam logic [5:0] dz = core_subset_pkg::OP_DEC_SKIP;
  localparam logic [5:0] iz = core_subset_pkg::OP_INC_SKIP;
  localparam logic [5:0] of = core_subset_pkg::OP_OR_FILE;
  localparam logic [5:0] ol = core_subset_pkg::OP_OR_LIT;
  logic clk_in = 1'b0, rst_b_in = 1'b0;
  logic [13:0] insn_in = 14'h0000;
  logic [7:0] rd = 8'h00, pins = 8'h00, latch = 8'h00, opt = 8'h00;
  core_subset_pkg::file_write_t fw;
  logic [12:0] pc;
  logic [6:0] fa;
  logic [7:0] w;
  logic z, clr, ce, sq;
  int err_count = 0, num_checks = 0, cycles = 0;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h, expected %h", $time, a, b); end end
  cpu_instruction_subset_exec cpu_instruction_subset_exec_inst (
    .clk_in, .rst_b_in, .insn_in, .file_rdata_in(rd), .port_pins_in(pins),
    .program_counter_high_latch_in(latch), .option_in(opt),
    .file_addr_out(fa), .file_write_out(fw), .pc_out(pc), .w_out(w),
    .zero_flag_out(z), .prescaler_clear_out(clr), .cycle_end_out(ce),
    .squash_out(sq));
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cycles == 2000) begin
    err_count++;
    end_of_test();
  end
  task automatic ex(logic [5:0] op, logic d, logic [6:0] f, logic [7:0] r);
    int n = 0;
    insn_in = {op, d, f};
    rd = r;
    do @(negedge clk_in); while (!(ce === 1'b1 && sq === 1'b0) && ++n < 20);
    if (n >= 20) err_count++;
    @(negedge clk_in);
  endtask : ex
  task t_dec;
    ex(dz, 1'b1, 7'h20, 8'h05);
    `CHK({fw, sq, z}, {1'b1, 7'h20, 8'h04, 1'b0, 1'b0})
    ex(dz, 1'b0, 7'h21, 8'h01);
    `CHK({w, sq, fw.valid, z}, {8'h00, 1'b1, 1'b0, 1'b0})
    `CHK(fa, 7'h21)
  endtask : t_dec
  task t_inc;
    ex(iz, 1'b0, 7'h22, 8'h7F);
    `CHK({w, sq}, {8'h80, 1'b0})
    ex(iz, 1'b1, 7'h23, 8'hFF);
    `CHK({fw.data, sq, z}, {8'h00, 1'b1, 1'b0})
  endtask : t_inc
  task t_or;
    ex(dz, 1'b0, 7'h24, 8'h01);
    ex(ol, 1'b0, 7'h00, 8'h00);
    `CHK({w, z}, {8'h00, 1'b1})
    ex(of, 1'b0, 7'h25, 8'h3C);
    `CHK({w, z, fw.valid}, {8'h3C, 1'b0, 1'b0})
    ex(ol, 1'b1, 7'h7F, 8'h00);
    `CHK({w, z}, {8'hFF, 1'b0})
    ex(of, 1'b1, 7'h25, 8'h00);
    `CHK({fw, w}, {1'b1, 7'h25, 8'hFF, 8'hFF})
  endtask : t_or
  task t_port;
    ex(dz, 1'b0, 7'h26, 8'h01);
    pins = 8'hA5;
    ex(of, 1'b0, core_subset_pkg::ADDR_PORT, 8'h5A);
    `CHK({w, z}, {8'hA5, 1'b0})
  endtask : t_port
  task t_branch;
    latch = 8'h18;
    ex(6'h2A, 1'b1, 7'h55, 8'h00);
    `CHK({pc, sq, z}, {13'h1AD5, 1'b1, 1'b0})
    ex(ol, 1'b0, 7'h00, 8'h00);
    `CHK(pc, 13'h1AD7)
  endtask : t_branch
  task t_timer;
    ex(dz, 1'b1, core_subset_pkg::ADDR_TIMER_ZERO, 8'h09);
    `CHK(clr, 1'b1)
    opt = 8'h08;
    ex(dz, 1'b1, core_subset_pkg::ADDR_TIMER_ZERO, 8'h09);
    `CHK(clr, 1'b0)
  endtask : t_timer
  task end_of_test;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    t_dec();
    t_inc();
    t_or();
    t_port();
    t_branch();
    t_timer();
    end_of_test();
  end
endmodule : tb_cpu_instruction_subset_exec
